/* File: spd_params.svh */
/*
  Constants for the split-port double-data-rate SRAM pin model: burst shape,
  address widths per organisation, lane widths and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

// ==========================================================================
// burst shape
`define SPD_BURST_LEN 4
`define SPD_BEAT_W 2
`define SPD_BEAT_FIRST 2'h0
`define SPD_BEAT_LAST 2'h3
`define SPD_BEAT_STEP 2'h1

// ==========================================================================
// organisations: data width and address width of each
`define SPD_DW_X8 8
`define SPD_DW_X9 9
`define SPD_DW_X18 18
`define SPD_DW_X36 36
`define SPD_AW_X8 21
`define SPD_AW_X9 21
`define SPD_AW_X18 20
`define SPD_AW_X36 19

// ==========================================================================
// write mask lanes: nibble lanes for x8, nine-bit lanes otherwise
`define SPD_LANE_W_NIBBLE 4
`define SPD_LANE_W_BYTE 9
`define SPD_MAX_DW 36
`define SPD_MAX_LANES 4

// ==========================================================================
// read buffer and reset values
`define SPD_FIFO_DEPTH 4
`define SPD_MASK_NONE_N 4'hF

`endif

/* File: spd_pkg.sv */
/*
  Types shared by the split-port SRAM pin model: the read sequencer states
  and the record that carries one captured write beat.
  Assumes spd_params.svh is on the include path.
*/
`include "spd_params.svh"

package spd_pkg;

  // ========================================================================
  // read sequencer, gray coded along idle -> fetch -> drain
  typedef enum logic [1:0] {
    SPD_RD_IDLE  = 2'h0,
    SPD_RD_FETCH = 2'h1,
    SPD_RD_DRAIN = 2'h3
  } spd_rd_state_t;

  // ========================================================================
  // one write beat: data and active-low lane masks, sized for the widest part
  typedef struct packed {
    logic [`SPD_MAX_DW-1:0] data;
    logic [`SPD_MAX_LANES-1:0] mask_n;
  } spd_beat_t;

endpackage

/* File: spd_sram.sv */
/*
  Pin-level model of a pipelined SRAM with separate write and read data
  ports, a shared address bus and four-word bursts, plus its read buffer.
  Assumes all pins are synchronous to core_clk_in; the input and output
  timing strobes are sampled as levels and their rising edges detected here,
  so each strobe must stay at one level for at least one core clock.
*/
// Summary of operation
// - write beats captured on both strobe rising edges
// - low write select at positive strobe starts write
// - deselected write port ignores data, array untouched
// - x8 nibble masks gate bits 3:0 and 7:4
// - nine-bit lanes gated by byte lane masks
// - masked lanes keep previous contents
// - masks sampled with their own data beat
// - one address bus for reads and writes
// - address width follows organisation, four words each
// - address ignored when its port is deselected
// - read beats driven on output timing edges
// - read bus floats at a positive output edge once the read is idle and drained
// - data bus widths follow organisation
// - read select starts four-beat burst, float after
// - accesses start only at positive strobe edge
`timescale 1ns/10ps
`include "spd_params.svh"

// ==========================================================================
// read data buffer
module spd_fifo #(
  parameter int WIDTH = `SPD_DW_X36,
  parameter int DEPTH = `SPD_FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } spd_fifo_state_t;

  spd_fifo_state_t s;
  spd_fifo_state_t next_s;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready_out = (s.count != CW'(DEPTH));
  assign out_valid_out = (s.count != '0);
  assign out_data_out = s.mem[s.rptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer wrap is explicit so depth need not be a power of two
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wptr] = in_data_in;
      next_s.wptr = (s.wptr == PW'(DEPTH - 1)) ? '0 : PW'(s.wptr + 1'b1);
    end
    if (pop) begin
      next_s.rptr = (s.rptr == PW'(DEPTH - 1)) ? '0 : PW'(s.rptr + 1'b1);
    end
    if (push && !pop) begin
      next_s.count = CW'(s.count + 1'b1);
    end else if (pop && !push) begin
      next_s.count = CW'(s.count - 1'b1);
    end
  end

  // register the state
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // spd_fifo

// ==========================================================================
// device top
module spd_sram #(
  parameter int DATA_W = `SPD_DW_X36,
  parameter int ADDR_W = `SPD_AW_X36,
  parameter int LANE_W = (DATA_W == `SPD_DW_X8) ? `SPD_LANE_W_NIBBLE : `SPD_LANE_W_BYTE,
  parameter int LANES = DATA_W / LANE_W
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic input_strobe_pos_in,
  input wire logic input_strobe_neg_in,
  input wire logic out_timing_pos_in,
  input wire logic out_timing_neg_in,
  input wire logic single_clk_mode_in,
  input wire logic write_port_sel_n_in,
  input wire logic read_port_sel_n_in,
  input wire logic [ADDR_W-1:0] word_index_in,
  input wire logic [DATA_W-1:0] write_beats_in,
  input wire logic [LANES-1:0] lane_mask_n_in,
  output logic [DATA_W-1:0] read_beats_out,
  output logic read_beats_oe_out
);
  localparam int IDX_W = ADDR_W + `SPD_BEAT_W;

  typedef struct packed {
    logic k_prev;
    logic kn_prev;
    logic c_prev;
    logic cn_prev;
    logic wr_busy;
    logic [`SPD_BEAT_W-1:0] wr_cnt;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_pend;
    logic [IDX_W-1:0] wr_idx;
    spd_pkg::spd_beat_t wr_beat;
    spd_pkg::spd_rd_state_t rd_state;
    logic [ADDR_W-1:0] rd_addr;
    logic [`SPD_BEAT_W-1:0] rd_cnt;
    logic [DATA_W-1:0] rd_q;
    logic rd_oe;
  } spd_top_state_t;

  spd_top_state_t s;
  spd_top_state_t next_s;
  // four array words behind every address
  logic [DATA_W-1:0] mem [0:(1 << IDX_W)-1];
  logic k_rise;
  logic kn_rise;
  logic out_pos;
  logic out_neg;
  logic out_edge;
  logic wr_start;
  logic beat_edge;
  logic [LANES-1:0] lane_we;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic [DATA_W-1:0] fetch_word;

  // edge detection on the sampled strobe levels
  assign k_rise = input_strobe_pos_in && !s.k_prev;
  assign kn_rise = input_strobe_neg_in && !s.kn_prev;
  // single clock mode reuses the input strobes for output timing
  assign out_pos = single_clk_mode_in ? k_rise : (out_timing_pos_in && !s.c_prev);
  assign out_neg = single_clk_mode_in ? kn_rise : (out_timing_neg_in && !s.cn_prev);
  assign out_edge = out_pos || out_neg;

  // a write is started only by a selected positive strobe while idle
  assign wr_start = k_rise && !write_port_sel_n_in && !s.wr_busy;
  // later beats alternate negative then positive strobe edges
  assign beat_edge = s.wr_busy && (s.wr_cnt[0] ? kn_rise : k_rise);

  // read fetch feeds the buffer; the buffer stalls the fetch when full
  assign fifo_in_valid = (s.rd_state == spd_pkg::SPD_RD_FETCH);
  assign fetch_word = mem[{s.rd_addr, s.rd_cnt}];

  // ========================================================================
  // read data buffer instance
  spd_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(`SPD_FIFO_DEPTH)
  ) spd_fifo_inst (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fetch_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(out_edge),
    .out_data_out(fifo_out_data)
  );

  // ========================================================================
  // next state for write capture, read sequencing and output drive
  always_comb begin
    next_s = s;
    next_s.k_prev = input_strobe_pos_in;
    next_s.kn_prev = input_strobe_neg_in;
    next_s.c_prev = out_timing_pos_in;
    next_s.cn_prev = out_timing_neg_in;
    next_s.wr_pend = 1'b0;
    // deselected write leaves data, mask and address unlatched
    if (wr_start) begin
      next_s.wr_busy = 1'b1;
      next_s.wr_addr = word_index_in;
      next_s.wr_cnt = `SPD_BEAT_STEP;
      next_s.wr_pend = 1'b1;
      next_s.wr_idx = {word_index_in, `SPD_BEAT_FIRST};
      next_s.wr_beat.data = `SPD_MAX_DW'(write_beats_in);
      next_s.wr_beat.mask_n = `SPD_MAX_LANES'(lane_mask_n_in);
    end else if (beat_edge) begin
      next_s.wr_pend = 1'b1;
      next_s.wr_idx = {s.wr_addr, s.wr_cnt};
      next_s.wr_beat.data = `SPD_MAX_DW'(write_beats_in);
      next_s.wr_beat.mask_n = `SPD_MAX_LANES'(lane_mask_n_in);
      next_s.wr_cnt = `SPD_BEAT_W'(s.wr_cnt + `SPD_BEAT_STEP);
      if (s.wr_cnt == `SPD_BEAT_LAST) begin
        next_s.wr_busy = 1'b0;
      end
    end
    // read burst: one address, four words pushed into the buffer
    case (s.rd_state)
      spd_pkg::SPD_RD_IDLE: begin
        if (k_rise && !read_port_sel_n_in) begin
          next_s.rd_addr = word_index_in;
          next_s.rd_cnt = `SPD_BEAT_FIRST;
          next_s.rd_state = spd_pkg::SPD_RD_FETCH;
        end
      end
      spd_pkg::SPD_RD_FETCH: begin
        if (fifo_in_ready) begin
          next_s.rd_cnt = `SPD_BEAT_W'(s.rd_cnt + `SPD_BEAT_STEP);
          if (s.rd_cnt == `SPD_BEAT_LAST) begin
            next_s.rd_state = spd_pkg::SPD_RD_DRAIN;
          end
        end
      end
      spd_pkg::SPD_RD_DRAIN: begin
        if (!fifo_out_valid) begin
          next_s.rd_state = spd_pkg::SPD_RD_IDLE;
        end
      end
      default: begin
        next_s.rd_state = spd_pkg::SPD_RD_IDLE;
      end
    endcase
    // pending beats finish; float only at a positive output edge after that
    if (out_edge && fifo_out_valid) begin
      next_s.rd_q = fifo_out_data;
      next_s.rd_oe = 1'b1;
    end else if (out_pos && s.rd_state == spd_pkg::SPD_RD_IDLE) begin
      next_s.rd_oe = 1'b0;
    end
  end

  // register the state
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
      s.wr_beat.mask_n <= `SPD_MASK_NONE_N;
    end else begin
      s <= next_s;
    end
  end

  // lane enables: a high mask bit keeps the lane out of the array
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_we[i] = s.wr_pend && !s.wr_beat.mask_n[i];
    end
  end

  // array write per lane; unselected lanes hold their old contents
  // no reset: the array contents are undefined at power up
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i]) begin
        mem[s.wr_idx][i*LANE_W +: LANE_W] <= s.wr_beat.data[i*LANE_W +: LANE_W];
      end
    end
  end

  assign read_beats_out = s.rd_q;
  assign read_beats_oe_out = s.rd_oe;

  // ========================================================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence seq_wr_req;
    k_rise && !write_port_sel_n_in && !s.wr_busy;
  endsequence

  sequence seq_rd_req;
    k_rise && !read_port_sel_n_in && s.rd_state == spd_pkg::SPD_RD_IDLE;
  endsequence

  sequence seq_wr_burst;
    s.wr_busy && s.wr_pend && s.wr_cnt == `SPD_BEAT_STEP;
  endsequence

  AST_WR_START: assert property (seq_wr_req |=> seq_wr_burst)
    else $error("selected write did not open a burst");

  AST_WR_ADDR: assert property (seq_wr_req |=> s.wr_addr == $past(word_index_in))
    else $error("write address not latched at start");

  AST_WR_DESEL: assert property (k_rise && write_port_sel_n_in && !s.wr_busy |=> !s.wr_pend)
    else $error("deselected write port touched the array");

  AST_BEAT_EDGE: assert property (s.wr_pend |-> $past(k_rise) || $past(kn_rise))
    else $error("write beat captured off a strobe edge");

  AST_MASK_GATE: assert property (seq_wr_req |=> lane_we == ~$past(lane_mask_n_in))
    else $error("lane enables do not follow the beat mask");

  AST_RD_START: assert property (seq_rd_req |=> s.rd_state == spd_pkg::SPD_RD_FETCH
                                 && s.rd_addr == $past(word_index_in))
    else $error("selected read did not start a burst");

  AST_START_ON_K: assert property ($rose(s.wr_busy) |-> $past(k_rise))
    else $error("write started off a positive strobe edge");

  AST_RD_DESEL: assert property (k_rise && read_port_sel_n_in && s.rd_state == spd_pkg::SPD_RD_IDLE
                                 |=> s.rd_state == spd_pkg::SPD_RD_IDLE)
    else $error("deselected read port started an access");

  AST_OUT_DRIVE: assert property (out_edge && fifo_out_valid |=> read_beats_oe_out
                                  && read_beats_out == $past(fifo_out_data))
    else $error("read beat not driven on output edge");

  AST_OUT_FLOAT: assert property (out_pos && !fifo_out_valid && s.rd_state == spd_pkg::SPD_RD_IDLE
                                  |=> !read_beats_oe_out)
    else $error("read bus did not float after deselect");

  AST_Q_STEADY: assert property (!out_edge |=> $stable(read_beats_out))
    else $error("read data changed without an output edge");

  // the buffer is empty whenever a read is taken, so the fetch never stalls
  AST_RD_BURST4: assert property (seq_rd_req |=> (s.rd_state == spd_pkg::SPD_RD_FETCH) [*4]
                                  ##1 (s.rd_state == spd_pkg::SPD_RD_DRAIN))
    else $error("read burst did not fetch four words");

  AST_WR_IDX: assert property (beat_edge |=> s.wr_idx == {$past(s.wr_addr), $past(s.wr_cnt)})
    else $error("write beat aimed at the wrong array word");

  AST_WR_END: assert property (s.wr_busy && s.wr_cnt == `SPD_BEAT_LAST && kn_rise
                               |=> !s.wr_busy && s.wr_pend)
    else $error("write burst did not close after the fourth beat");
endmodule // spd_sram

/* File: spd_ctrl_model.sv */
/*
  Behavioural model of the memory controller that faces the SRAM pins:
  input strobes, output timing strobes, port selects, address, write beats.
  Assumes the bench calls its tasks and that every change lands on a
  falling edge of core_clk_in, so the device samples settled levels.
*/
`timescale 1ns/10ps

// ==========================================================================
// controller model
module spd_ctrl_model #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 19,
  parameter int LANES = 4
) (
  input wire logic core_clk_in,
  output logic [3:0] strobes_out,
  output logic write_port_sel_n_out,
  output logic read_port_sel_n_out,
  output logic [ADDR_W-1:0] word_index_out,
  output logic [DATA_W-1:0] write_beats_out,
  output logic [LANES-1:0] lane_mask_n_out
);
  // idle levels: strobes low so no edge is seen at reset release
  initial begin
    strobes_out = 4'h0;
    write_port_sel_n_out = 1'b1;
    read_port_sel_n_out = 1'b1;
    word_index_out = '0;
    write_beats_out = '0;
    lane_mask_n_out = '1;
  end

  // one strobe pulse: high one core cycle, low two, selects valid meanwhile
  task automatic pulse(input int idx, input logic wsel_n, input logic rsel_n, input logic [ADDR_W-1:0] addr);
    @(negedge core_clk_in);
    write_port_sel_n_out = wsel_n;
    read_port_sel_n_out = rsel_n;
    word_index_out = addr;
    strobes_out[idx] = 1'b1;
    @(negedge core_clk_in);
    strobes_out[idx] = 1'b0;
    write_port_sel_n_out = 1'b1;
    read_port_sel_n_out = 1'b1;
    word_index_out = ~addr; // released address shows junk, not the old value
    @(negedge core_clk_in);
  endtask

  // four-beat write: beats alternate positive and negative strobe rises
  task automatic write_burst(input logic sel_n, input logic [ADDR_W-1:0] addr, input logic [4*DATA_W-1:0] data,
                             input logic [4*LANES-1:0] mask_n);
    for (int b = 0; b < 4; b++) begin
      @(negedge core_clk_in);
      write_port_sel_n_out = (b == 0) ? sel_n : 1'b1;
      word_index_out = addr;
      write_beats_out = data[b*DATA_W +: DATA_W];
      lane_mask_n_out = mask_n[b*LANES +: LANES];
      strobes_out[b % 2] = 1'b1;
      @(negedge core_clk_in);
      strobes_out[b % 2] = 1'b0;
      @(negedge core_clk_in);
    end
    write_port_sel_n_out = 1'b1;
    word_index_out = ~addr;
    write_beats_out = ~write_beats_out;
    lane_mask_n_out = ~lane_mask_n_out;
  endtask
endmodule // spd_ctrl_model

/* File: spd_sram_tb.sv */
/*
  Self-checking bench for the split-port SRAM pin model in its x36 form.
  Assumes spd_ctrl_model drives the device pins and that read data is
  settled one core cycle after each output edge.
*/
`timescale 1ns/10ps

// ==========================================================================
// bench top
module spd_sram_tb;
  localparam int DW = 36;
  localparam int AW = 19;
  localparam int LN = 4;
  localparam logic [AW-1:0] ADDR_A = 19'h2A5C3;
  localparam logic [4*DW-1:0] DATA_1 = {36'h123456789, 36'hABCDEF012, 36'h3456789AB, 36'hCDEF01234};
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic single_clk_mode = 1'b0;
  logic [3:0] stb;
  logic wps_n, rps_n, oe;
  logic [AW-1:0] idx;
  logic [DW-1:0] wdata, rdata;
  logic [LN-1:0] mask_n;
  logic [DW-1:0] shadow [4];
  int miscompares = 0;
  int compares = 0;

  spd_ctrl_model #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) spd_ctrl_model_inst (
    .core_clk_in(core_clk_in), .strobes_out(stb), .write_port_sel_n_out(wps_n),
    .read_port_sel_n_out(rps_n), .word_index_out(idx), .write_beats_out(wdata), .lane_mask_n_out(mask_n));

  spd_sram #(.DATA_W(DW), .ADDR_W(AW)) spd_sram_inst (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .input_strobe_pos_in(stb[0]), .input_strobe_neg_in(stb[1]),
    .out_timing_pos_in(stb[2]), .out_timing_neg_in(stb[3]), .single_clk_mode_in(single_clk_mode),
    .write_port_sel_n_in(wps_n), .read_port_sel_n_in(rps_n), .word_index_in(idx), .write_beats_in(wdata),
    .lane_mask_n_in(mask_n), .read_beats_out(rdata), .read_beats_oe_out(oe));

  // 50 MHz core clock
  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end

  task automatic check(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // write a burst to ADDR_A and keep the expected words, lane by lane
  task automatic do_write(input logic sel_n, input logic [4*DW-1:0] data, input logic [4*LN-1:0] m);
    spd_ctrl_model_inst.write_burst(sel_n, ADDR_A, data, m);
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < LN; i++) begin
        if (!sel_n && !m[b*LN+i]) begin
          shadow[b][i*9 +: 9] = data[b*DW+i*9 +: 9];
        end
      end
    end
    repeat (3) @(negedge core_clk_in);
  endtask

  // read ADDR_A; buffer fills while output edges stall, then drains
  task automatic read_check(input logic extra);
    int ob;
    ob = single_clk_mode ? 0 : 2;
    spd_ctrl_model_inst.pulse(0, 1'b1, 1'b0, ADDR_A);
    if (extra) begin
      spd_ctrl_model_inst.pulse(0, 1'b1, 1'b0, ~ADDR_A); // refused while fetching
    end
    repeat (6) @(negedge core_clk_in);
    for (int b = 0; b < 4; b++) begin
      spd_ctrl_model_inst.pulse(ob + b % 2, 1'b1, 1'b1, ~ADDR_A);
      check("read beat", shadow[b], rdata);
      check("oe driving", 36'h000000001, {35'h0, oe});
    end
    spd_ctrl_model_inst.pulse(ob, 1'b1, 1'b1, ~ADDR_A);
    check("oe floats", 36'h000000000, {35'h0, oe});
  endtask

  task automatic test_basic();
    do_write(1'b0, DATA_1, 16'h0000);
    read_check(1'b1);
    $display("test basic write and read done");
  endtask

  task automatic test_masks();
    do_write(1'b0, ~DATA_1, 16'h8421);
    read_check(1'b0);
    $display("test lane masks done");
  endtask

  task automatic test_deselect();
    do_write(1'b1, DATA_1 ^ {4{36'h5A5A5A5A5}}, 16'h0000);
    spd_ctrl_model_inst.pulse(1, 1'b0, 1'b1, ADDR_A);
    repeat (3) @(negedge core_clk_in);
    read_check(1'b0);
    $display("test deselected write done");
  endtask

  task automatic test_single();
    @(negedge core_clk_in);
    single_clk_mode = 1'b1;
    read_check(1'b0);
    @(negedge core_clk_in);
    single_clk_mode = 1'b0;
    $display("test single clock mode done");
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    $display("ERROR timeout expected end seen hang");
    summarize();
  end

  // main sequence: reset held five cycles, first access after two more
  initial begin
    repeat (5) @(negedge core_clk_in);
    check("reset data", 36'h000000000, rdata);
    check("reset oe", 36'h000000000, {35'h0, oe});
    rst_b_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    test_basic();
    test_masks();
    test_deselect();
    test_single();
    summarize();
  end
endmodule // spd_sram_tb
